// [pkg/bcg_pkg.sv]
// Constants and encodings for the bit-clear, guard-clear and invert executor
// Operation
// - Bit-zero forces only the selected bit of the addressed byte to 0 and alters no flag.
// - Single guard-clear resets the watchdog counter and clears expiry and power-down flags.
// - First paired guard-clear takes effect only when alternated with the second one.
// - Second paired guard-clear takes effect only when alternated with the first one.
// - Invert writes the one's complement back to the same byte and updates only zero flag.
package bcg_pkg;

  // Data path shape
  localparam int DATA_W = 8;
  localparam int BIT_W  = 3;
  localparam int ADDR_W = 6;
  localparam int DEPTH  = 64;

  // Operation codes on the opcode input
  localparam logic [2:0] OP_NOP          = 3'h0;
  localparam logic [2:0] OP_BIT_ZERO     = 3'h1;
  localparam logic [2:0] OP_SINGLE_GUARD = 3'h2;
  localparam logic [2:0] OP_FIRST_GUARD  = 3'h3;
  localparam logic [2:0] OP_SECOND_GUARD = 3'h4;
  localparam logic [2:0] OP_INVERT       = 3'h5;

  // Reset values of the flags
  localparam logic EXPIRY_RST     = 1'b0;
  localparam logic POWER_DOWN_RST = 1'b0;
  localparam logic ZERO_RST       = 1'b0;

  // Paired guard-clear tracker states
  typedef enum logic [1:0] {
    PAIR_IDLE,
    PAIR_AFTER_FIRST,
    PAIR_AFTER_SECOND
  } bcg_pair_state_t;

endpackage : bcg_pkg

// [rtl/bcg_pair_guard.sv]
// Tracker that lets paired guard-clears act only when they alternate
`timescale 1ns/1ps
module bcg_pair_guard (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstSyncN,
  input  wire logic ce,
  // Paired requests, one-cycle
  input  wire logic firstReq,
  input  wire logic secondReq,
  // Combinational grant in the request cycle
  output logic      pairClear
);

  bcg_pkg::bcg_pair_state_t state_q;
  bcg_pkg::bcg_pair_state_t state_d;

  // A lone repeat keeps waiting; only the opposite half completes the pair
  always_comb begin
    state_d   = state_q;
    pairClear = 1'b0;
    case (state_q)
      bcg_pkg::PAIR_IDLE: begin
        if (firstReq) begin
          state_d = bcg_pkg::PAIR_AFTER_FIRST;
        end else if (secondReq) begin
          state_d = bcg_pkg::PAIR_AFTER_SECOND;
        end
      end
      bcg_pkg::PAIR_AFTER_FIRST: begin
        if (secondReq) begin
          pairClear = 1'b1;
          state_d   = bcg_pkg::PAIR_IDLE;
        end
      end
      bcg_pkg::PAIR_AFTER_SECOND: begin
        if (firstReq) begin
          pairClear = 1'b1;
          state_d   = bcg_pkg::PAIR_IDLE;
        end
      end
      default: begin
        state_d = bcg_pkg::PAIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= bcg_pkg::PAIR_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

endmodule : bcg_pair_guard

// [rtl/bcg_exec.sv]
// Executor for bit-zero, guard-clear and invert operations on a local data memory
`timescale 1ns/1ps
module bcg_exec #(
  parameter int DATA_W = bcg_pkg::DATA_W,
  parameter int BIT_W  = bcg_pkg::BIT_W,
  parameter int ADDR_W = bcg_pkg::ADDR_W,
  parameter int DEPTH  = bcg_pkg::DEPTH
) (
  // Clock, reset and enable
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Instruction issue
  input  wire logic              opValid,
  input  wire logic [2:0]        opCode,
  input  wire logic [ADDR_W-1:0] opAddr,
  input  wire logic [BIT_W-1:0]  opBit,
  // Memory preload from the rest of the core
  input  wire logic              loadEn,
  input  wire logic [ADDR_W-1:0] loadAddr,
  input  wire logic [DATA_W-1:0] loadData,
  // Memory observation
  input  wire logic [ADDR_W-1:0] peekAddr,
  output logic      [DATA_W-1:0] peekData,
  // Events from the watchdog and power logic
  input  wire logic              expiryEvent,
  input  wire logic              powerDownEvent,
  // Results
  output logic                   watchdogClear,
  output logic                   expiryFlag,
  output logic                   powerDownFlag,
  output logic                   zeroFlag,
  output logic                   opDone
);

  // Reset synchroniser
  logic rstMeta_q;
  logic rstSync_q;

  // Decoded requests
  logic bitZeroReq;
  logic singleReq;
  logic firstReq;
  logic secondReq;
  logic invertReq;
  logic pairClear;
  logic guardClear;

  // Data path
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] curByte;
  logic [DATA_W-1:0] clearMask;
  logic [DATA_W-1:0] bitZeroByte;
  logic [DATA_W-1:0] invertByte;
  logic [DATA_W-1:0] wrByte;
  logic              wrEn;

  // Output registers
  logic [DATA_W-1:0] peekData_q;
  logic              watchdogClear_q;
  logic              expiryFlag_q;
  logic              powerDownFlag_q;
  logic              zeroFlag_q;
  logic              opDone_q;

  // Asserted asynchronously, released after two edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Decode; a disabled clock makes every request void
  always_comb begin
    bitZeroReq = 1'b0;
    singleReq  = 1'b0;
    firstReq   = 1'b0;
    secondReq  = 1'b0;
    invertReq  = 1'b0;
    if (opValid && ce) begin
      case (opCode)
        bcg_pkg::OP_BIT_ZERO:     bitZeroReq = 1'b1;
        bcg_pkg::OP_SINGLE_GUARD: singleReq  = 1'b1;
        bcg_pkg::OP_FIRST_GUARD:  firstReq   = 1'b1;
        bcg_pkg::OP_SECOND_GUARD: secondReq  = 1'b1;
        bcg_pkg::OP_INVERT:       invertReq  = 1'b1;
        default: begin
          bitZeroReq = 1'b0;
        end
      endcase
    end
  end

  bcg_pair_guard u_pair (
    .clock     (clock),
    .rstSyncN  (rstSync_q),
    .ce        (ce),
    .firstReq  (firstReq),
    .secondReq (secondReq),
    .pairClear (pairClear)
  );

  assign guardClear = singleReq || pairClear;

  // One mask bit per data bit: only the selected position is cleared
  assign curByte = mem_q[opAddr];
  for (genvar b = 0; b < DATA_W; b++) begin : g_mask
    assign clearMask[b] = (opBit == BIT_W'(b));
  end
  assign bitZeroByte = curByte & ~clearMask;
  assign invertByte  = ~curByte;

  // Instruction write-back wins over a preload in the same cycle
  always_comb begin
    wrEn   = 1'b0;
    wrByte = curByte;
    if (bitZeroReq) begin
      wrEn   = 1'b1;
      wrByte = bitZeroByte;
    end else if (invertReq) begin
      wrEn   = 1'b1;
      wrByte = invertByte;
    end
  end

  // Memory is data, not control: it has no reset and is preloaded by the core
  always_ff @(posedge clock) begin
    if (ce) begin
      if (wrEn) begin
        mem_q[opAddr] <= wrByte;
      end else if (loadEn) begin
        mem_q[loadAddr] <= loadData;
      end
    end
  end

  // Observation port, one cycle latency
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      peekData_q <= '0;
    end else if (ce) begin
      peekData_q <= mem_q[peekAddr];
    end
  end

  // Counter clear pulse to the watchdog
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      watchdogClear_q <= 1'b0;
    end else if (ce) begin
      watchdogClear_q <= guardClear;
    end
  end

  // A set arriving with a clear wins, so an event is never lost
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      expiryFlag_q <= bcg_pkg::EXPIRY_RST;
    end else if (ce) begin
      if (expiryEvent) begin
        expiryFlag_q <= 1'b1;
      end else if (guardClear) begin
        expiryFlag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      powerDownFlag_q <= bcg_pkg::POWER_DOWN_RST;
    end else if (ce) begin
      if (powerDownEvent) begin
        powerDownFlag_q <= 1'b1;
      end else if (guardClear) begin
        powerDownFlag_q <= 1'b0;
      end
    end
  end

  // Only the invert touches the zero flag; bit-zero leaves it alone
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      zeroFlag_q <= bcg_pkg::ZERO_RST;
    end else if (ce) begin
      if (invertReq) begin
        zeroFlag_q <= (invertByte == '0);
      end
    end
  end

  // Completion pulse for every recognised operation, effective or not
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      opDone_q <= 1'b0;
    end else if (ce) begin
      opDone_q <= bitZeroReq || singleReq || firstReq || secondReq || invertReq;
    end
  end

  assign peekData      = peekData_q;
  assign watchdogClear = watchdogClear_q;
  assign expiryFlag    = expiryFlag_q;
  assign powerDownFlag = powerDownFlag_q;
  assign zeroFlag      = zeroFlag_q;
  assign opDone        = opDone_q;

endmodule : bcg_exec

// [bench/bcg_exec_properties.sv]
// Concurrent checks on the ports of the executor
`timescale 1ns/1ps
module bcg_exec_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       ce,
  // Issue and observation
  input wire logic       opValid,
  input wire logic [2:0] opCode,
  input wire logic [5:0] opAddr,
  input wire logic       loadEn,
  input wire logic [5:0] peekAddr,
  input wire logic [7:0] peekData,
  input wire logic       expiryEvent,
  input wire logic       powerDownEvent,
  // Results
  input wire logic       watchdogClear,
  input wire logic       expiryFlag,
  input wire logic       powerDownFlag,
  input wire logic       zeroFlag
);
  logic go;
  logic quiet;
  assign go = opValid && ce;
  assign quiet = !expiryEvent && !powerDownEvent;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  single_clear_a: assert property (go && opCode == bcg_pkg::OP_SINGLE_GUARD && quiet
    |=> watchdogClear && !expiryFlag && !powerDownFlag) else $error("single clear missed");
  bit_zero_flags_a: assert property (go && opCode == bcg_pkg::OP_BIT_ZERO
    |=> $stable(zeroFlag) && !watchdogClear) else $error("bit zero touched a flag");
  // Peek lags one cycle, so it shows the byte the invert read, before its write
  invert_zero_a: assert property (go && opCode == bcg_pkg::OP_INVERT && peekAddr == opAddr
    && !$past(opValid) && !$past(loadEn) |=> zeroFlag == (peekData == 8'hFF))
    else $error("zero flag wrong after invert");
  invert_flags_a: assert property (go && opCode == bcg_pkg::OP_INVERT && quiet
    |=> $stable(expiryFlag) && $stable(powerDownFlag) && !watchdogClear)
    else $error("invert touched other flags");
  first_repeat_a: assert property (go && opCode == bcg_pkg::OP_FIRST_GUARD
    ##1 go && opCode == bcg_pkg::OP_FIRST_GUARD |=> !watchdogClear) else $error("first repeat");
  second_repeat_a: assert property (go && opCode == bcg_pkg::OP_SECOND_GUARD
    ##1 go && opCode == bcg_pkg::OP_SECOND_GUARD |=> !watchdogClear) else $error("second repeat");
  // A frozen enable holds the pulse, so only enabled edges are judged
  clear_source_a: assert property (watchdogClear && $past(ce) |-> $past(go)
    && $past(opCode) inside {[3'h2:3'h4]}) else $error("clear without guard op");
  expiry_source_a: assert property ($rose(expiryFlag) || $rose(powerDownFlag)
    |-> $past(expiryEvent) || $past(powerDownEvent)) else $error("flag rose without event");
  cover property (go && opCode == bcg_pkg::OP_FIRST_GUARD ##1 go && opCode == 3'h4);
  cover property (watchdogClear);
  cover property (go && opCode == bcg_pkg::OP_INVERT ##1 zeroFlag);
endmodule : bcg_exec_properties

bind bcg_exec bcg_exec_properties chk_u (.clock, .rst_n, .ce, .opValid, .opCode, .opAddr,
  .loadEn, .peekAddr, .peekData, .expiryEvent, .powerDownEvent, .watchdogClear,
  .expiryFlag, .powerDownFlag, .zeroFlag);

// [bench/bcg_exec_tb.sv]
// Self-checking bench of the executor
`timescale 1ns/1ps
module bcg_exec_tb;
  logic        clock, rst_n, ce, opValid, loadEn, expiryEvent, powerDownEvent, pend, wc;
  logic        watchdogClear, expiryFlag, powerDownFlag, zeroFlag, opDone, expF, power_down_flag, zF, ceLast;
  logic [2:0]  opCode, opBit, armed, rc;
  logic [5:0]  opAddr, loadAddr, peekAddr;
  logic [7:0]  loadData, peekData, pendMem;
  logic [7:0]  mem [64];
  logic [11:0] q [$];
  logic [11:0] n;
  int          err_total, num_checks, seed, i;

  bcg_exec dut_u (.clock, .rst_n, .ce, .opValid, .opCode, .opAddr, .opBit, .loadEn,
    .loadAddr, .loadData, .peekAddr, .peekData, .expiryEvent, .powerDownEvent,
    .watchdogClear, .expiryFlag, .powerDownFlag, .zeroFlag, .opDone);

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [11:0] got, input logic [11:0] want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clock);
      opValid <= 0;
      loadEn <= 0;
      expiryEvent <= 0;
      powerDownEvent <= 0;
    end
  endtask : idle

  task automatic ld(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    {loadEn, loadAddr, loadData} <= {1'b1, a, d};
    mem[a] = d;
  endtask : ld

  task automatic ev;
    @(posedge clock);
    {expiryEvent, powerDownEvent} <= 2'h3;
    opValid <= 0;
    {expF, power_down_flag} = 2'h3;
  endtask : ev

  // Issue, then model; back-to-back calls give one op per cycle
  task automatic op(input logic [2:0] c, input logic [5:0] a, input logic [2:0] b);
    @(posedge clock);
    {opValid, opCode, opAddr, opBit} <= {1'b1, c, a, b};
    // Events are one-cycle pulses, so a clear issued right after one is not overruled
    {expiryEvent, powerDownEvent} <= 2'h0;
    wc = ce && c == bcg_pkg::OP_SINGLE_GUARD;
    if (ce && c == bcg_pkg::OP_BIT_ZERO)
      mem[a][b] = 0;
    if (ce && c == bcg_pkg::OP_INVERT) begin
      mem[a] = ~mem[a];
      zF = mem[a] == 8'h00;
    end
    if (ce && (c == bcg_pkg::OP_FIRST_GUARD || c == bcg_pkg::OP_SECOND_GUARD)) begin
      wc = armed === (c ^ 3'h7);
      armed = wc ? 3'h0 : c;
    end
    if (wc)
      {expF, power_down_flag} = 2'h0;
    if (ce && c inside {[3'h1:3'h5]})
      q.push_back({wc, expF, power_down_flag, zF, mem[a]});
  endtask : op

  always @(posedge clock) peekAddr <= opAddr;

  // Outputs only move after an enabled edge; a frozen pulse is not a new result
  always @(posedge clock) begin
    if (ceLast === 1'b1) begin
      if (pend)
        check({4'h0, peekData}, {4'h0, pendMem});
      pend = 0;
      if (opDone === 1'b1) begin
        n = (q.size() > 0) ? q.pop_front() : 12'hFFF;
        check({watchdogClear, expiryFlag, powerDownFlag, zeroFlag, 8'h00}, {n[11:8], 8'h00});
        {pend, pendMem} = {1'b1, n[7:0]};
      end
    end
    ceLast = ce;
  end

  initial begin
    seed = 30;
    {err_total, num_checks, pend, armed, expF, power_down_flag, zF, ceLast} = 0;
    {rst_n, ce, opValid, loadEn, expiryEvent, powerDownEvent} = 0;
    {opCode, opBit, opAddr, loadAddr, loadData, peekAddr} = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1;
    ce <= 1;
    idle(4);
    for (i = 0; i < 16; i++) ld(6'(i), (i == 8) ? 8'hFF : 8'($random(seed)));
    idle(1);
    ev();
    for (i = 0; i < 8; i++) op(bcg_pkg::OP_BIT_ZERO, 6'(i), 3'(i));
    idle(2);
    ev();
    op(bcg_pkg::OP_SINGLE_GUARD, 0, 0);
    idle(2);
    ev();
    op(bcg_pkg::OP_FIRST_GUARD, 0, 0);
    op(bcg_pkg::OP_FIRST_GUARD, 0, 0);
    idle(1);
    op(bcg_pkg::OP_SECOND_GUARD, 0, 0);
    idle(2);
    ev();
    op(bcg_pkg::OP_SECOND_GUARD, 0, 0);
    op(bcg_pkg::OP_SECOND_GUARD, 0, 0);
    op(bcg_pkg::OP_FIRST_GUARD, 0, 0);
    ev();
    op(bcg_pkg::OP_FIRST_GUARD, 0, 0);
    op(bcg_pkg::OP_SECOND_GUARD, 0, 0);
    for (i = 0; i < 3; i++) begin
      idle(2);
      op(bcg_pkg::OP_INVERT, 8, 0);
    end
    idle(1);
    ce <= 0;
    op(bcg_pkg::OP_INVERT, 8, 0);
    idle(1);
    ce <= 1;
    op(3'h6, 8, 0);
    for (i = 0; i < 30; i++) begin
      rc = 3'h1 + 3'($unsigned($random(seed)) % 5);
      op(rc, 6'($random(seed)) & 6'h0F, 3'($random(seed)));
    end
    idle(4);
    check(12'(q.size()), 12'h000);
    tally_and_finish();
  end

  // Whole sequence needs well under 400 cycles
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule : bcg_exec_tb
